// ===== hdl/etat_sequencer.sv
// edge trigger acquisition sequencer with single and continuous strobes
// assumes trigIn is asynchronous; config ports are static during a cycle
`timescale 1ns/1ps
`include "etat_params.svh"
module etat_sequencer #(
    parameter int TW = 32,
    parameter int BUSY2_US = `ETAT_BUSY2_US
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // trigger pin
    input wire logic trigIn,
    // configuration, in microseconds
    input wire logic [TW-1:0] acqDelay,
    input wire logic [TW-1:0] integTime,
    input wire logic [TW-1:0] strobeDelay,
    input wire logic [TW-1:0] singlePulseWidth,
    input wire logic [TW-1:0] contPeriod,
    // outputs
    output logic singleStrobe,
    output logic contStrobe,
    output logic busy,
    output logic integrating,
    output logic triggerEvent
);
    localparam int ECW = 4;
    localparam int TKW = 8;
    localparam logic [ECW-1:0] EVT_CYC = ECW'(`ETAT_EVT_DLY_CYC);
    localparam logic [TKW-1:0] TICK_LAST = TKW'(`ETAT_TICK_CYC - 1);

    logic trigMeta, trigSync, trigPrev;
    logic [TKW-1:0] tickCnt, next_tickCnt;
    logic tick;
    etat_pkg::etat_state_t state, next_state;
    logic [ECW-1:0] evtCnt, next_evtCnt;
    logic [TW-1:0] phaseCnt, next_phaseCnt;
    logic [TW-1:0] ssCnt, next_ssCnt;
    logic ssPhase, next_ssPhase; // 0 delay, 1 width
    logic ssDone, next_ssDone;
    logic [TW-1:0] csCnt, next_csCnt;
    logic [TW-1:0] intLeft, next_intLeft;
    logic next_single, next_cont, next_busy, next_integ, next_evt;
    logic [TW-1:0] busy1Time;
    logic rise;

    // train runs only for a non-zero period below the integration time
    function automatic logic trainAllowed(input logic [TW-1:0] per,
                                          input logic [TW-1:0] integ);
        return (per != '0) && (per < integ);
    endfunction : trainAllowed

    // initial busy depends on integration time
    always_comb begin
        if (integTime >= TW'(`ETAT_BUSY1_LIMIT_US)) begin
            busy1Time = TW'(`ETAT_BUSY1_SHORT_US); // R12
        end else begin
            busy1Time = TW'(`ETAT_BUSY1_BASE_US) - integTime; // R12
        end
    end

    assign rise = trigSync && !trigPrev; // R1
    assign tick = (tickCnt == TICK_LAST); // R15

    // synchroniser and tick divider
    always_comb begin
        next_tickCnt = tick ? '0 : tickCnt + 1'b1; // R15
        if (state == etat_pkg::EVTDLY && evtCnt == '0) begin
            next_tickCnt = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            trigMeta <= 1'b0;
            trigSync <= 1'b0;
            trigPrev <= 1'b0;
            tickCnt <= '0;
        end else begin
            trigMeta <= trigIn;
            trigSync <= trigMeta;
            trigPrev <= trigSync;
            tickCnt <= next_tickCnt;
        end
    end

    // sequence and strobes
    always_comb begin
        next_state = state;
        next_evtCnt = evtCnt;
        next_phaseCnt = phaseCnt;
        next_ssCnt = ssCnt;
        next_ssPhase = ssPhase;
        next_ssDone = ssDone;
        next_csCnt = csCnt;
        next_intLeft = intLeft;
        next_single = singleStrobe;
        next_cont = contStrobe;
        next_evt = 1'b0;
        case (state)
            etat_pkg::IDLE: begin
                next_single = 1'b0;
                next_cont = 1'b0;
                if (rise) begin // R1 R16
                    next_state = etat_pkg::EVTDLY;
                    // synchroniser already spent three cycles
                    next_evtCnt = EVT_CYC - ECW'(3); // R3
                end
            end
            etat_pkg::EVTDLY: begin
                if (evtCnt == '0) begin
                    next_evt = 1'b1; // R3
                    next_state = etat_pkg::BUSY1;
                    next_phaseCnt = busy1Time + acqDelay; // R4 R11
                    next_ssCnt = strobeDelay; // R5
                    next_ssPhase = 1'b0;
                    next_ssDone = 1'b0;
                    if (strobeDelay == '0 && singlePulseWidth != '0) begin
                        next_single = 1'b1; // R6
                        next_ssPhase = 1'b1;
                        next_ssCnt = singlePulseWidth;
                    end
                end else begin
                    next_evtCnt = evtCnt - 1'b1;
                end
            end
            etat_pkg::BUSY1, etat_pkg::INTEG: begin
                if (tick && !ssDone) begin
                    if (ssCnt > TW'(1)) begin
                        next_ssCnt = ssCnt - 1'b1; // R5
                    end else if (!ssPhase && singlePulseWidth != '0) begin
                        next_single = 1'b1; // R6
                        next_ssPhase = 1'b1;
                        next_ssCnt = singlePulseWidth;
                    end else begin
                        next_single = 1'b0; // R6
                        next_ssDone = 1'b1;
                    end
                end
                if (state == etat_pkg::BUSY1 && tick) begin
                    if (phaseCnt <= TW'(1)) begin
                        next_state = etat_pkg::INTEG; // R8 R14
                        next_phaseCnt = integTime; // R14
                        next_intLeft = integTime;
                        next_csCnt = '0;
                        // R9 R10
                        next_cont = trainAllowed(contPeriod, integTime);
                    end else begin
                        next_phaseCnt = phaseCnt - 1'b1;
                    end
                end
                if (state == etat_pkg::INTEG && tick) begin
                    next_intLeft = intLeft - 1'b1;
                    if (csCnt + 1'b1 >= contPeriod) begin
                        next_csCnt = '0;
                        // start a new period only if it fits
                        next_cont = trainAllowed(contPeriod, integTime) &&
                                    (contPeriod <= intLeft - 1'b1); // R9
                    end else begin
                        next_csCnt = csCnt + 1'b1;
                        if (csCnt + 1'b1 == (contPeriod >> 1)) begin
                            next_cont = 1'b0; // R13
                        end
                    end
                    if (phaseCnt <= TW'(1)) begin
                        next_state = etat_pkg::BUSY2;
                        next_phaseCnt = TW'(BUSY2_US); // R4
                        next_single = 1'b0; // R7
                        next_ssDone = 1'b1;
                        next_cont = 1'b0; // R9
                    end else begin
                        next_phaseCnt = phaseCnt - 1'b1;
                    end
                end
            end
            etat_pkg::BUSY2: begin
                next_single = 1'b0;
                next_cont = 1'b0;
                if (tick) begin
                    if (phaseCnt <= TW'(1)) begin
                        next_state = etat_pkg::IDLE; // R16
                    end else begin
                        next_phaseCnt = phaseCnt - 1'b1;
                    end
                end
            end
            default: begin
                next_state = etat_pkg::IDLE;
            end
        endcase
        next_busy = (next_state != etat_pkg::IDLE);
        next_integ = (next_state == etat_pkg::INTEG);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state <= etat_pkg::IDLE;
            evtCnt <= '0;
            phaseCnt <= '0;
            ssCnt <= '0;
            ssPhase <= 1'b0;
            ssDone <= 1'b1;
            csCnt <= '0;
            intLeft <= '0;
            singleStrobe <= 1'b0;
            contStrobe <= 1'b0;
            busy <= 1'b0;
            integrating <= 1'b0;
            triggerEvent <= 1'b0;
        end else begin
            state <= next_state;
            evtCnt <= next_evtCnt;
            phaseCnt <= next_phaseCnt;
            ssCnt <= next_ssCnt;
            ssPhase <= next_ssPhase;
            ssDone <= next_ssDone;
            csCnt <= next_csCnt;
            intLeft <= next_intLeft;
            singleStrobe <= next_single;
            contStrobe <= next_cont;
            busy <= next_busy;
            integrating <= next_integ;
            triggerEvent <= next_evt;
        end
    end
endmodule : etat_sequencer

// ===== hdl/etat_params.svh
// constants for the edge trigger acquisition timing sequencer
// assumes a 250 MHz ref_clk; all user times are in 1 us ticks
// Function
// (R1) Only a rising trigger edge starts a cycle; that edge is the reference.
// (R2) Trigger source keeps the input high at least 10 ns after rising.
// (R3) Trigger event is declared 20 to 30 ns after the rising edge.
// (R4) Event, initial busy plus acquisition delay, integration, final busy.
// (R5) Single strobe delay counts from the trigger event, in 1 us steps.
// (R6) Single strobe goes high after its delay for the programmed width.
// (R7) Single strobe is forced low when integration ends.
// (R8) Continuous strobe train starts exactly when integration starts.
// (R9) Only full continuous strobe periods are emitted inside integration.
// (R10) Train is active only when its period is below integration time.
// (R11) Acquisition delay 0 to 335500 us, 1 us steps, before integration.
// (R12) Initial busy is 1 us if integration >= 218 us, else 219 minus it.
// (R13) Each continuous pulse is high half the period, low the other half; code lowers it after contPeriod>>1 us, never for a 1 us period.
// (R14) Acquisition delay never changes the integration length.
// (R15) A 1 us tick from the system clock drives all timing counters; the event delay counter evtCnt counts ref_clk cycles instead.
// (R16) Further rising edges are ignored until final busy has ended.
`ifndef ETAT_PARAMS_SVH
`define ETAT_PARAMS_SVH
`define ETAT_CLK_MHZ 250
`define ETAT_TICK_US 1
`define ETAT_TICK_CYC (`ETAT_CLK_MHZ * `ETAT_TICK_US)
`define ETAT_EVT_DLY_MIN_NS 20
`define ETAT_EVT_DLY_MAX_NS 30
`define ETAT_CLK_PERIOD_NS 4
// least delay rounded up to whole cycles
`define ETAT_EVT_DLY_CYC \
    ((`ETAT_EVT_DLY_MIN_NS + `ETAT_CLK_PERIOD_NS - 1) / `ETAT_CLK_PERIOD_NS)
`define ETAT_ACQ_DLY_MAX_US 335500
`define ETAT_BUSY1_SHORT_US 1
`define ETAT_BUSY1_LIMIT_US 218
`define ETAT_BUSY1_BASE_US 219
`define ETAT_BUSY2_US 218
`endif

// ===== hdl/etat_pkg.sv
// types for the edge trigger acquisition timing sequencer
// assumes etat_params.svh supplies the numeric constants
package etat_pkg;
    typedef enum logic [2:0] {
        IDLE,
        EVTDLY,
        BUSY1,
        INTEG,
        BUSY2
    } etat_state_t;
endpackage : etat_pkg

// ===== verif/etat_sequencer_sva.sv
// port assertions for the acquisition sequencer
// assumes it is bound onto etat_sequencer
`timescale 1ns/1ps
module etat_sequencer_sva #(parameter int TW = 32) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // watched ports
    input wire logic trigIn,
    input wire logic [TW-1:0] integTime,
    input wire logic [TW-1:0] contPeriod,
    input wire logic singleStrobe,
    input wire logic contStrobe,
    input wire logic busy,
    input wire logic integrating,
    input wire logic triggerEvent
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic trainOn;
    assign trainOn = contPeriod != '0 && contPeriod < integTime;
    a_event_from_edge: assert property (
        $rose(trigIn) && !busy |-> ##[3:8] triggerEvent)
        else $error("no trigger event after pin edge");
    a_event_once: assert property (
        triggerEvent |-> busy && !$past(busy, 4))
        else $error("trigger event late in a busy cycle");
    a_integ_busy: assert property (integrating |-> busy && !triggerEvent)
        else $error("integration outside busy");
    a_final_busy: assert property ($fell(integrating) |-> busy [*8])
        else $error("final busy too short");
    a_train_start: assert property (
        $rose(integrating) && trainOn |-> contStrobe)
        else $error("train did not start with integration");
    a_train_off: assert property (!trainOn |-> !contStrobe)
        else $error("train active with bad period");
    a_train_inside: assert property (contStrobe |-> integrating)
        else $error("train outside integration");
    a_strobe_cut: assert property (
        $fell(integrating) |-> !singleStrobe && !contStrobe)
        else $error("strobes not low at integration end");
    a_strobe_busy: assert property (singleStrobe |-> busy)
        else $error("single strobe while idle");
    cover property (triggerEvent);
    cover property ($fell(contStrobe) && integrating);
    cover property ($fell(busy));
endmodule : etat_sequencer_sva

// ===== verif/etat_trig_src.sv
// trigger source driving the trigger pin
// assumes fire is a one-cycle request set at a falling edge
`timescale 1ns/1ps
module etat_trig_src (
    // clock and request
    input wire logic ref_clk,
    input wire logic fire,
    // trigger pin
    output logic trigIn
);
    initial trigIn = 1'b0;
    always @(negedge ref_clk) begin
        if (fire) begin
            trigIn <= 1'b1;
            repeat (3) @(negedge ref_clk);
            trigIn <= 1'b0;
        end
    end
endmodule : etat_trig_src

// ===== verif/etat_sequencer_tb.sv
// self-checking bench for the acquisition sequencer
// assumes one edge-triggered cycle plus an edge while busy
`timescale 1ns/1ps
module etat_sequencer_tb;
    localparam int U = 250;
    localparam int B2 = 3;
    localparam int INTEG = 217;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic fire = 1'b0;
    logic trigIn, singleStrobe, contStrobe, busy, integrating, triggerEvent;
    logic [31:0] acqDelay, integTime, strobeDelay, singlePulseWidth;
    logic [31:0] contPeriod;
    logic [4:0] cur, up, dn;
    logic [4:0] prv = '0;
    int seed = 80;
    int mismatches = 0;
    int samples_checked = 0;
    int cyc, nEv, nCs, tEv, tIr, tIf, tSr, tSf, tCr, tCf, tBf, acq, sd, per;
    realtime tPin, tEvT;
    assign cur = {busy, contStrobe, singleStrobe, integrating, triggerEvent};
    assign up = cur & ~prv;
    assign dn = ~cur & prv;
    etat_sequencer #(.TW(32), .BUSY2_US(B2)) DUT (
        .ref_clk(ref_clk), .rst_b(rst_b), .trigIn(trigIn),
        .acqDelay(acqDelay), .integTime(integTime),
        .strobeDelay(strobeDelay), .singlePulseWidth(singlePulseWidth),
        .contPeriod(contPeriod), .singleStrobe(singleStrobe),
        .contStrobe(contStrobe), .busy(busy), .integrating(integrating),
        .triggerEvent(triggerEvent));
    etat_trig_src src (.ref_clk(ref_clk), .fire(fire), .trigIn(trigIn));
    always #2 ref_clk = ~ref_clk;
    task automatic chk(input int got, input int exp, input int tol);
        samples_checked++;
        if (got < exp - tol || got > exp + tol) begin
            mismatches++;
            $display("[FAIL] %0t got %0d expected %0d", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    always @(posedge trigIn) if (tPin == 0) tPin = $realtime;
    // outputs are watched at the falling edge, where they have settled
    always @(negedge ref_clk) begin
        cyc++;
        if (cur[0] === 1'b1) nEv++;
        if (cur[0] === 1'b1 && nEv == 1) tEv = cyc;
        if (cur[0] === 1'b1 && nEv == 1) tEvT = $realtime - 2.0;
        if (up[1] === 1'b1) tIr = cyc;
        if (dn[1] === 1'b1) tIf = cyc;
        if (up[2] === 1'b1) tSr = cyc;
        if (dn[2] === 1'b1) tSf = cyc;
        if (up[3] === 1'b1) nCs++;
        if (up[3] === 1'b1 && nCs == 1) tCr = cyc;
        if (dn[3] === 1'b1 && nCs == 1) tCf = cyc;
        if (dn[4] === 1'b1) tBf = cyc;
        prv <= cur;
        if (cyc > 70000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    initial begin
        acq = $unsigned($random(seed)) % 4;
        sd = $unsigned($random(seed)) % 16;
        per = 3 + $unsigned($random(seed)) % 38;
        acqDelay = acq;
        integTime = INTEG;
        strobeDelay = sd;
        singlePulseWidth = 32'h0000012c;
        contPeriod = per;
        repeat (20) @(negedge ref_clk);
        rst_b <= 1'b1;
        repeat (3) @(negedge ref_clk);
        fire <= 1'b1;
        @(negedge ref_clk);
        fire <= 1'b0;
        repeat (400) @(negedge ref_clk);
        fire <= 1'b1;
        @(negedge ref_clk);
        fire <= 1'b0;
        while (tBf == 0) @(negedge ref_clk);
        chk(int'(tEvT - tPin), 25, 5);
        chk(nEv, 1, 0);
        chk(tIr - tEv, (219 - INTEG + acq) * U, 1);
        chk(tIf - tIr, INTEG * U, 0);
        chk(tBf - tIf, B2 * U, 1);
        chk(tSr - tEv, sd * U, 1);
        chk(tSf - tIf, 0, 1);
        chk(tCr - tIr, 0, 0);
        chk(nCs, INTEG / per, 0);
        chk(tCf - tCr, per / 2 * U, 0);
        tally_and_finish();
    end
endmodule : etat_sequencer_tb
bind etat_sequencer etat_sequencer_sva #(.TW(TW)) u_sva (
    .ref_clk(ref_clk), .rst_b(rst_b), .trigIn(trigIn),
    .integTime(integTime), .contPeriod(contPeriod),
    .singleStrobe(singleStrobe), .contStrobe(contStrobe), .busy(busy),
    .integrating(integrating), .triggerEvent(triggerEvent));
